// ### common/odwp_link_if.sv
`timescale 1ns/1ns
interface odwp_link_if;
   logic       selected;
   logic       frame_start;
   logic       frame_end;
   logic       rise_stb;
   logic       byte_stb;
   logic [7:0] byte_val;
   logic       wp_n_s;

   modport front (output selected, frame_start, frame_end, rise_stb, byte_stb, byte_val, wp_n_s);
   modport core  (input  selected, frame_start, frame_end, rise_stb, byte_stb, byte_val, wp_n_s);
endinterface

// ### common/odwp_pkg.sv
package odwp_pkg;

   // Opcodes, MSb first on the serial input
   localparam logic [7:0] OPC_LATCH_SET      = 8'h06;
   localparam logic [7:0] OPC_LATCH_CLEAR    = 8'h04;
   localparam logic [7:0] OPC_STATUS_READ    = 8'h05;
   localparam logic [7:0] OPC_STATUS_WRITE   = 8'h01;
   localparam logic [7:0] OPC_ARRAY_WRITE    = 8'h02;
   localparam logic [7:0] OPC_ARRAY_READ     = 8'h03;
   localparam logic [7:0] OPC_FAST_READ      = 8'h0b;
   localparam logic [7:0] OPC_SECTOR_WRITE   = 8'h42;
   localparam logic [7:0] OPC_SECTOR_READ    = 8'h4b;
   localparam logic [7:0] OPC_DEVICE_ID_READ = 8'h9f;
   localparam logic [7:0] OPC_UNIQUE_ID_READ = 8'h4c;
   localparam logic [7:0] OPC_SERIAL_WRITE   = 8'hc2;
   localparam logic [7:0] OPC_SERIAL_READ    = 8'hc3;
   localparam logic [7:0] OPC_DEEP_SLEEP     = 8'hba;
   localparam logic [7:0] OPC_HIBERNATE      = 8'hb9;

   // Status register field positions
   localparam int SR_PROTECT_PIN_EN_BIT = 7;
   localparam int SR_FIXED_ONE_BIT      = 6;
   localparam int SR_FIXED_ZERO_HI_BIT  = 5;
   localparam int SR_FIXED_ZERO_LO_BIT  = 4;
   localparam int SR_BP_HI_BIT          = 3;
   localparam int SR_BP_LO_BIT          = 2;
   localparam int SR_WEL_BIT            = 1;
   localparam int SR_BUSY_BIT           = 0;

   // Reset values
   localparam logic [1:0] BP_RESET       = 2'h0;
   localparam logic       PROTECT_PIN_ENABLE_RESET     = 1'b0;
   localparam logic       WEL_RESET      = 1'b0;
   localparam logic [7:0] SR_RESET       = 8'h40;

   // Array geometry and protected region bases
   localparam int          ADDR_W       = 20;
   localparam int          ADDR_BYTES   = 3;
   localparam logic [19:0] QUARTER_BASE = 20'hc0000;
   localparam logic [19:0] HALF_BASE    = 20'h80000;
   localparam int          BITS_PER_BYTE = 8;

   typedef enum logic [2:0] {
      ODWP_IDLE,
      ODWP_STATUS_RD,
      ODWP_STATUS_WR,
      ODWP_ADDR,
      ODWP_PASS,
      ODWP_IGNORE
   } odwp_state_t;

endpackage

// ### hw/odwp_spi_front.sv
`timescale 1ns/1ns
module odwp_spi_front
   import odwp_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  reset,
   input  wire logic  cs_n,
   input  wire logic  sck,
   input  wire logic  si,
   input  wire logic  wp_n,
   odwp_link_if.front lk
);

   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;
   logic       cs_n_d_ff;
   logic       sck_d_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic       byte_stb_ff;
   logic [7:0] byte_val_ff;
   logic       cs_n_s;
   logic       sck_s;
   logic       si_s;
   logic       sck_rise;

   // Pins come from the master's domain, so two stages before any use
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_ff <= 4'hf;
         sync2_ff <= 4'hf;
      end else begin
         sync1_ff <= {wp_n, si, sck, cs_n};
         sync2_ff <= sync1_ff;
      end
   end

   assign cs_n_s = sync2_ff[0];
   assign sck_s  = sync2_ff[1];
   assign si_s   = sync2_ff[2];

   always_ff @(posedge clk) begin
      if (reset) begin
         cs_n_d_ff <= 1'b1;
         sck_d_ff  <= 1'b1;
      end else begin
         cs_n_d_ff <= cs_n_s;
         sck_d_ff  <= sck_s;
      end
   end

   // Mode 3 idles high, so only a real low-to-high change counts as a bit
   assign sck_rise = sck_s & ~sck_d_ff & ~cs_n_s;

   always_ff @(posedge clk) begin
      if (reset || cs_n_s) begin
         bit_cnt_ff  <= 3'h0;
         shift_ff    <= 8'h00;
         byte_stb_ff <= 1'b0;
         byte_val_ff <= 8'h00;
      end else begin
         byte_stb_ff <= 1'b0;
         if (sck_rise) begin
            shift_ff   <= {shift_ff[6:0], si_s};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
               byte_stb_ff <= 1'b1;
               byte_val_ff <= {shift_ff[6:0], si_s};
            end
         end
      end
   end

   assign lk.selected    = ~cs_n_s;
   assign lk.frame_start = cs_n_d_ff & ~cs_n_s;
   assign lk.frame_end   = ~cs_n_d_ff & cs_n_s;
   assign lk.rise_stb    = byte_stb_ff ? 1'b0 : sck_rise;
   assign lk.byte_stb    = byte_stb_ff;
   assign lk.byte_val    = byte_val_ff;
   assign lk.wp_n_s      = sync2_ff[3];

endmodule

// ### hw/odwp_top.sv
`timescale 1ns/1ns
// How it works
// - Fifteen opcodes are known; any other value gets no function.
// - Opcode 06h sets the write-enable latch, 04h clears it, MSb first.
// - Opcode 05h returns the status byte; 01h writes the status register.
// - Opcodes 02h array write, 03h array read, 0Bh fast array read.
// - Opcode 42h special-sector write, 4Bh special-sector read.
// - BAh deep sleep, B9h hibernate; bit 0 may read nonzero while waking.
// - Unknown opcode: ignore input until next select, keep output tristated.
// - First byte after select is the opcode; one opcode per select.
// - After reset the write-enable latch is clear.
// - Latch-set sets the latch, seen in status bit 1.
// - Status-write data never changes the write-enable flag.
// - Latch clears on deselect after latch-clear or any write command.
// - Latch-clear blocks all writes; master may confirm flag reads 0.
// - Status: protect-pin enable bit 7, block protect 3:2, flag bit 1.
// - Bits 4, 5 read 0, bit 6 reads 1, bit 0 shows wake in progress; writes leave them.
// - Block-protect bits are nonvolatile, factory value 0.
// - Code 01 protects top quarter, 10 top half, 11 everything.
// - Array writes gated by latch and block protect only, not the pin.
// - Status write refused if latch clear, or enable bit 1 and pin low.
module odwp_top
   import odwp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic       si,
   input  wire logic       wp_n,
   input  wire logic       wake_in_progress,
   input  wire logic [1:0] nv_bp_in,
   output logic            so,
   output logic            so_oe,
   output logic [7:0]      opcode,
   output logic            opcode_stb,
   output logic [7:0]      status,
   output logic            array_wr_ok,
   output logic            nv_bp_store
);

   odwp_link_if lk ();

   odwp_spi_front u_front (
      .clk   (clk),
      .reset (reset),
      .cs_n  (cs_n),
      .sck   (sck),
      .si    (si),
      .wp_n  (wp_n),
      .lk    (lk)
   );

   odwp_state_t state_ff;
   odwp_state_t nxt_state;
   logic        wel_ff;
   logic        protect_pin_enable_ff;
   logic [1:0]  bp_ff;
   logic        nv_load_ff;
   logic        clr_pend_ff;
   logic [7:0]  sr_ff;
   logic [7:0]  sr_sh_ff;
   logic        so_ff;
   logic        so_oe_ff;
   logic [7:0]  opcode_ff;
   logic        opcode_stb_ff;
   logic [23:0] addr_ff;
   logic [1:0]  addr_cnt_ff;
   logic        array_ok_ff;
   logic        nv_store_ff;
   logic        opc_stb;
   logic        sr_data_stb;
   logic        sr_allowed;
   logic [7:0]  nxt_sr;

   function automatic logic known_opc(input logic [7:0] b);
      case (b)
         OPC_LATCH_SET, OPC_LATCH_CLEAR, OPC_STATUS_READ, OPC_STATUS_WRITE,
         OPC_ARRAY_WRITE, OPC_ARRAY_READ, OPC_FAST_READ, OPC_SECTOR_WRITE,
         OPC_SECTOR_READ, OPC_DEVICE_ID_READ, OPC_UNIQUE_ID_READ,
         OPC_SERIAL_WRITE, OPC_SERIAL_READ, OPC_DEEP_SLEEP,
         OPC_HIBERNATE: known_opc = 1'b1;
         default:       known_opc = 1'b0;
      endcase
   endfunction

   function automatic logic clears_latch(input logic [7:0] b);
      case (b)
         OPC_LATCH_CLEAR, OPC_STATUS_WRITE, OPC_ARRAY_WRITE,
         OPC_SECTOR_WRITE, OPC_SERIAL_WRITE: clears_latch = 1'b1;
         default:                            clears_latch = 1'b0;
      endcase
   endfunction

   function automatic logic in_protected(input logic [1:0] bp, input logic [19:0] a);
      case (bp)
         2'h1:    in_protected = (a >= QUARTER_BASE);
         2'h2:    in_protected = (a >= HALF_BASE);
         2'h3:    in_protected = 1'b1;
         default: in_protected = 1'b0;
      endcase
   endfunction

   // The opcode is only the first byte of a selection
   assign opc_stb     = lk.byte_stb && (state_ff == ODWP_IDLE);
   assign sr_data_stb = lk.byte_stb && (state_ff == ODWP_STATUS_WR);
   assign sr_allowed  = wel_ff && !(protect_pin_enable_ff && !lk.wp_n_s);

   always_comb begin
      nxt_state = state_ff;
      if (lk.frame_start || lk.frame_end || !lk.selected) begin
         nxt_state = ODWP_IDLE;
      end else if (opc_stb) begin
         case (lk.byte_val)
            OPC_STATUS_READ:  nxt_state = ODWP_STATUS_RD;
            OPC_STATUS_WRITE: nxt_state = ODWP_STATUS_WR;
            OPC_ARRAY_WRITE:  nxt_state = ODWP_ADDR;
            default:          nxt_state = known_opc(lk.byte_val) ? ODWP_PASS : ODWP_IGNORE;
         endcase
      end else if (sr_data_stb) begin
         nxt_state = ODWP_PASS;
      end else if (lk.byte_stb && state_ff == ODWP_ADDR && addr_cnt_ff == 2'(ADDR_BYTES - 1)) begin
         nxt_state = ODWP_PASS;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= ODWP_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Latch set on the opcode, cleared only at the closing deselect
   always_ff @(posedge clk) begin
      if (reset) begin
         wel_ff      <= WEL_RESET;
         clr_pend_ff <= 1'b0;
      end else begin
         if (lk.frame_end) begin
            clr_pend_ff <= 1'b0;
            if (clr_pend_ff) begin
               wel_ff <= 1'b0;
            end
         end else if (opc_stb) begin
            clr_pend_ff <= clears_latch(lk.byte_val);
            if (lk.byte_val == OPC_LATCH_SET) begin
               wel_ff <= 1'b1;
            end
         end
      end
   end

   // Block-protect bits are restored from the nonvolatile copy after reset
   always_ff @(posedge clk) begin
      if (reset) begin
         protect_pin_enable_ff     <= PROTECT_PIN_ENABLE_RESET;
         bp_ff       <= BP_RESET;
         nv_load_ff  <= 1'b1;
         nv_store_ff <= 1'b0;
      end else begin
         nv_store_ff <= 1'b0;
         nv_load_ff  <= 1'b0;
         if (nv_load_ff) begin
            bp_ff <= nv_bp_in;
         end else if (sr_data_stb && sr_allowed) begin
            protect_pin_enable_ff     <= lk.byte_val[SR_PROTECT_PIN_EN_BIT];
            bp_ff       <= lk.byte_val[SR_BP_HI_BIT:SR_BP_LO_BIT];
            nv_store_ff <= 1'b1;
         end
      end
   end

   always_comb begin
      nxt_sr                       = 8'h00;
      nxt_sr[SR_PROTECT_PIN_EN_BIT] = protect_pin_enable_ff;
      nxt_sr[SR_FIXED_ONE_BIT]      = 1'b1;
      nxt_sr[SR_BP_HI_BIT]          = bp_ff[1];
      nxt_sr[SR_BP_LO_BIT]          = bp_ff[0];
      nxt_sr[SR_WEL_BIT]            = wel_ff;
      nxt_sr[SR_BUSY_BIT]           = wake_in_progress;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sr_ff <= SR_RESET;
      end else begin
         sr_ff <= nxt_sr;
      end
   end

   // Shifting on the sampled rising edge leaves three to four clk cycles of hold after it
   always_ff @(posedge clk) begin
      if (reset) begin
         sr_sh_ff <= 8'h00;
      end else if (lk.byte_stb && (opc_stb ? lk.byte_val == OPC_STATUS_READ
                                           : state_ff == ODWP_STATUS_RD)) begin
         sr_sh_ff <= sr_ff;
      end else if (lk.rise_stb && state_ff == ODWP_STATUS_RD) begin
         sr_sh_ff <= {sr_sh_ff[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         so_ff    <= 1'b0;
         so_oe_ff <= 1'b0;
      end else begin
         so_ff    <= sr_sh_ff[7];
         so_oe_ff <= (state_ff == ODWP_STATUS_RD) && lk.selected;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         opcode_ff     <= 8'h00;
         opcode_stb_ff <= 1'b0;
      end else begin
         opcode_stb_ff <= opc_stb && known_opc(lk.byte_val);
         if (opc_stb) begin
            opcode_ff <= lk.byte_val;
         end
      end
   end

   // Write grant for the data phase that follows the address
   always_ff @(posedge clk) begin
      if (reset || lk.frame_start || lk.frame_end) begin
         addr_ff     <= 24'h000000;
         addr_cnt_ff <= 2'h0;
         array_ok_ff <= 1'b0;
      end else if (lk.byte_stb && state_ff == ODWP_ADDR) begin
         addr_ff     <= {addr_ff[15:0], lk.byte_val};
         addr_cnt_ff <= addr_cnt_ff + 2'h1;
         if (addr_cnt_ff == 2'(ADDR_BYTES - 1)) begin
            array_ok_ff <= wel_ff && !in_protected(bp_ff, {addr_ff[11:0], lk.byte_val});
         end
      end
   end

   assign so          = so_ff;
   assign so_oe       = so_oe_ff;
   assign opcode      = opcode_ff;
   assign opcode_stb  = opcode_stb_ff;
   assign status      = sr_ff;
   assign array_wr_ok = array_ok_ff;
   assign nv_bp_store = nv_store_ff;

   property p_wel_set;
      @(posedge clk) disable iff (reset)
      (opc_stb && lk.byte_val == OPC_LATCH_SET) |=> wel_ff ##1 status[SR_WEL_BIT];
   endproperty
   a_wel_set: assert property (p_wel_set) else $error("latch not set");

   property p_wel_clear;
      @(posedge clk) disable iff (reset)
      (lk.frame_end && clr_pend_ff) |=> !wel_ff;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared at deselect");

   property p_reserved;
      @(posedge clk) disable iff (reset)
      (opc_stb && !known_opc(lk.byte_val) && lk.selected) |=> state_ff == ODWP_IGNORE ##1 !so_oe;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved opcode acted on");

   property p_fixed_bits;
      @(posedge clk) disable iff (reset)
      status[SR_FIXED_ONE_BIT] && !status[SR_FIXED_ZERO_HI_BIT] && !status[SR_FIXED_ZERO_LO_BIT];
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong");

   property p_sr_refused;
      @(posedge clk) disable iff (reset)
      (sr_data_stb && (!wel_ff || (protect_pin_enable_ff && !lk.wp_n_s)) && !nv_load_ff) |=> $stable(bp_ff) && $stable(protect_pin_enable_ff);
   endproperty
   a_sr_refused: assert property (p_sr_refused) else $error("refused status write took effect");

   property p_sr_keeps_wel;
      @(posedge clk) disable iff (reset)
      sr_data_stb |=> wel_ff == $past(wel_ff);
   endproperty
   a_sr_keeps_wel: assert property (p_sr_keeps_wel) else $error("status write changed latch");

   property p_one_opcode;
      @(posedge clk) disable iff (reset)
      (state_ff != ODWP_IDLE && lk.selected && !lk.frame_start) |=> state_ff != ODWP_IDLE || !lk.selected;
   endproperty
   a_one_opcode: assert property (p_one_opcode) else $error("second opcode in one selection");

   property p_all_protected;
      @(posedge clk) disable iff (reset)
      (lk.byte_stb && state_ff == ODWP_ADDR && addr_cnt_ff == 2'h2 && bp_ff == 2'h3) |=> !array_wr_ok;
   endproperty
   a_all_protected: assert property (p_all_protected) else $error("write granted in protected array");

   property p_reset_wel;
      @(posedge clk) reset |=> !wel_ff;
   endproperty
   a_reset_wel: assert property (p_reset_wel) else $error("latch set after reset");

endmodule

// ### test/odwp_spi_master.sv
`timescale 1ns/1ns
module odwp_spi_master (
   input  wire logic clk,
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   logic oe_seen;
   logic mode3;

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      oe_seen = 1'b0;
      mode3 = 1'b0;
   end

   // Any drive inside a selection is noted, not only at sampled bits
   always @(so_oe) begin
      if (so_oe === 1'b1 && cs_n === 1'b0) oe_seen = 1'b1;
   end

   // Mode 0 idles sck low, mode 3 high; sck stands still between selections
   task automatic set_mode(input logic m3);
      mode3 = m3;
      sck = m3;
      #200;
   endtask

   // Select on a falling clk edge; bit edges are offset so none lands on a rising clk edge
   task automatic xfer(input logic [31:0] data, input int nbits, input bit keep, output logic [31:0] rx);
      rx = '0;
      oe_seen = 1'b0;
      @(negedge clk);
      cs_n = 1'b0;
      #97;
      for (int i = nbits - 1; i >= 0; i--) begin
         si = data[i];
         if (mode3) sck = 1'b0;
         #62;
         // A released output shows the inverse of its last value, so stale data cannot pass
         rx = {rx[30:0], (so_oe === 1'b1) ? so : ~so};
         sck = 1'b1;
         #63;
         if (!mode3) sck = 1'b0;
      end
      // Nothing may rely on SI after the last bit, so it is flipped
      si = ~si;
      #100;
      if (!keep) end_frame();
   endtask

   // Deselect gap of 20 clocks, well above the 4 the core needs
   task automatic end_frame();
      @(negedge clk);
      cs_n = 1'b1;
      #200;
   endtask
endmodule

// ### test/odwp_top_tb.sv
`timescale 1ns/1ns
module odwp_top_tb;
   import odwp_pkg::*;
   logic        clk, reset, cs_n, sck, si, wp_n, wake_in_progress;
   logic        so, so_oe, opcode_stb, array_wr_ok, nv_bp_store;
   logic [1:0]  nv_bp_in;
   logic [7:0]  opcode, status;
   logic [31:0] rx;
   int          num_errors, checks, stb_cnt, nv_cnt, n0;
   localparam logic [7:0]  OPS [15] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0b, 8'h42,
                                        8'h4b, 8'h9f, 8'h4c, 8'hc2, 8'hc3, 8'hba, 8'hb9};
   localparam logic [7:0]  BAD [5] = '{8'h00, 8'h07, 8'h10, 8'ha5, 8'hff};
   localparam logic [19:0] ADR [5] = '{20'h7ffff, 20'h80000, 20'hbffff, 20'hc0000, 20'hfffff};

   odwp_top i_odwp_top (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
      .wake_in_progress(wake_in_progress), .nv_bp_in(nv_bp_in), .so(so), .so_oe(so_oe),
      .opcode(opcode), .opcode_stb(opcode_stb), .status(status), .array_wr_ok(array_wr_ok),
      .nv_bp_store(nv_bp_store));
   odwp_spi_master i_odwp_spi_master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (opcode_stb === 1'b1) stb_cnt++;
      if (nv_bp_store === 1'b1) nv_cnt++;
   end

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      cmp_byte({7'h0, got}, {7'h0, exp}, what);
   endtask

   task automatic cmd(input logic [31:0] data, input int nbits);
      i_odwp_spi_master.xfer(data, nbits, 1'b0, rx);
   endtask

   task automatic wr_status(input logic [7:0] v);
      cmd(32'h06, 8);
      cmd({16'h0, 8'h01, v}, 16);
   endtask

   task automatic do_reset();
      @(negedge clk);
      reset = 1'b1;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      repeat (5) @(negedge clk);
   endtask

   // Expected protection worked out from the block-protect table
   function automatic logic prot(input logic [1:0] bp, input logic [19:0] a);
      case (bp)
         2'h0: prot = 1'b0;
         2'h1: prot = a >= 20'hc0000;
         2'h2: prot = a >= 20'h80000;
         default: prot = 1'b1;
      endcase
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #600_000;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      test_done();
   end

   initial begin
      reset = 1'b1;
      wp_n = 1'b1;
      wake_in_progress = 1'b0;
      nv_bp_in = 2'h0;
      do_reset();
      cmp_byte(status, 8'h40, "reset status");
      cmd({16'h0, 8'h05, 8'h06}, 16);
      cmp_byte(rx[7:0], 8'h40, "status read");
      wake_in_progress = 1'b1;
      repeat (3) @(negedge clk);
      cmp_bit(status[0], 1'b1, "waking bit");
      wake_in_progress = 1'b0;
      repeat (3) @(negedge clk);
      cmp_bit(status[0], 1'b0, "bit 0");
      $display("test reset done");
      foreach (OPS[i]) begin
         n0 = stb_cnt;
         cmd({24'h0, OPS[i]}, 8);
         cmp_byte(8'(stb_cnt - n0), 8'h01, "known strobe");
         cmp_byte(opcode, OPS[i], "opcode");
      end
      foreach (BAD[i]) begin
         n0 = stb_cnt;
         cmd({8'h0, BAD[i], 8'h06, 8'h05}, 24);
         cmp_byte(8'(stb_cnt - n0), 8'h00, "reserved strobe");
         cmp_bit(i_odwp_spi_master.oe_seen, 1'b0, "output enable");
         cmp_bit(status[1], 1'b0, "flag after reserved");
      end
      $display("test opcodes done");
      cmd(32'h06, 8);
      cmp_bit(status[1], 1'b1, "flag set");
      n0 = stb_cnt;
      cmd({16'h0, 8'h05, 8'h04}, 16);
      cmp_byte(rx[7:0], 8'h42, "status byte");
      cmp_byte(8'(stb_cnt - n0), 8'h01, "one opcode");
      cmp_bit(status[1], 1'b1, "second byte ignored");
      cmd(32'h04, 8);
      cmp_bit(status[1], 1'b0, "flag cleared");
      n0 = nv_cnt;
      cmd({16'h0, 8'h01, 8'h8c}, 16);
      cmp_byte(status, 8'h40, "write without latch");
      cmp_byte(8'(nv_cnt - n0), 8'h00, "no store");
      wr_status(8'hff);
      cmp_byte(status, 8'hcc, "accepted write");
      cmp_byte(8'(nv_cnt - n0), 8'h01, "store pulse");
      @(negedge clk);
      wp_n = 1'b0;
      wr_status(8'h00);
      cmp_byte(status, 8'hcc, "pin blocks write");
      @(negedge clk);
      wp_n = 1'b1;
      wr_status(8'h00);
      cmp_byte(status, 8'h40, "pin high allows");
      @(negedge clk);
      wp_n = 1'b0;
      wr_status(8'h04);
      cmp_byte(status, 8'h44, "pin ignored");
      $display("test status done");
      i_odwp_spi_master.set_mode(1'b1);
      cmd(32'h06, 8);
      cmp_bit(status[1], 1'b1, "mode 3 flag set");
      cmd({16'h0, 8'h05, 8'h00}, 16);
      cmp_byte(rx[7:0], 8'h46, "mode 3 status");
      cmd(32'h04, 8);
      cmp_bit(status[1], 1'b0, "mode 3 flag cleared");
      i_odwp_spi_master.set_mode(1'b0);
      $display("test mode 3 done");
      for (int b = 0; b < 4; b++) begin
         @(negedge clk);
         wp_n = 1'b1;
         wr_status({4'h8, 2'(b), 2'h0});
         cmp_byte(status, {4'hc, 2'(b), 2'h0}, "protect setup");
         @(negedge clk);
         wp_n = 1'b0;
         foreach (ADR[j]) begin
            cmd(32'h06, 8);
            i_odwp_spi_master.xfer({8'h02, 4'ha, ADR[j]}, 32, 1'b1, rx);
            cmp_bit(array_wr_ok, !prot(2'(b), ADR[j]), "array write");
            i_odwp_spi_master.end_frame();
         end
         i_odwp_spi_master.xfer({8'h02, 24'h0}, 32, 1'b1, rx);
         cmp_bit(array_wr_ok, 1'b0, "write after deselect");
         i_odwp_spi_master.end_frame();
      end
      $display("test array done");
      nv_bp_in = 2'h2;
      do_reset();
      cmp_byte(status, 8'h48, "restored protect");
      $display("test restore done");
      test_done();
   end
endmodule
